// File: sccu_pkg.sv
package sccu_pkg;
   localparam int          NCH           = 4;
   localparam logic [7:0]  CMD_PAGE      = 8'h00;
   localparam logic [7:0]  CMD_OPERATION = 8'h01;
   localparam logic [7:0]  CMD_ONOFF     = 8'h02;
   localparam logic [7:0]  CMD_CLEAR     = 8'h03;
   localparam logic [7:0]  CMD_WLOCK     = 8'h10;
   localparam logic [7:0]  CMD_STORE     = 8'h11;
   localparam logic [7:0]  CMD_RESTORE   = 8'h12;
   localparam logic [7:0]  CMD_FEATURE   = 8'h19;
   localparam logic [7:0]  CMD_VFORMAT   = 8'h20;
   localparam logic [7:0]  CMD_NOMINAL   = 8'h21;
   localparam logic [7:0]  CMD_MHIGH     = 8'h25;
   localparam logic [7:0]  CMD_MLOW      = 8'h26;
   localparam logic [7:0]  CMD_SLEW      = 8'h27;
   localparam logic [7:0]  CMD_SCALE     = 8'h29;
   localparam logic [7:0]  PAGE_ALL      = 8'hFF;
   localparam logic [7:0]  WL_ONLY_WL    = 8'h80;
   localparam logic [7:0]  WL_OPS        = 8'h40;
   localparam logic [7:0]  WL_VOUT       = 8'h20;
   localparam logic [7:0]  WL_RESET      = 8'h00;
   localparam logic [7:0]  FEATURE_VALUE = 8'h90;
   localparam logic [7:0]  VFORMAT_VALUE = 8'h40;
   localparam logic [7:0]  OP_OFF        = 8'h00;
   localparam logic [7:0]  OP_SOFTOFF    = 8'h40;
   localparam logic [7:0]  OP_NOMINAL    = 8'h80;
   localparam logic [7:0]  OP_MLOW_IGN   = 8'h94;
   localparam logic [7:0]  OP_MLOW_ACT   = 8'h98;
   localparam logic [7:0]  OP_MHIGH_IGN  = 8'hA4;
   localparam logic [7:0]  OP_MHIGH_ACT  = 8'hA8;
   localparam logic [15:0] RATE_HOLD     = 16'h0000;
   localparam logic [15:0] RATE_FAST     = 16'h7FFF;
   localparam logic [15:0] DAC_MAX       = 16'd4090;
   localparam logic [15:0] WORD_RESET    = 16'h0000;
   localparam logic [7:0]  SCALE_MASK    = 8'h7F;
   localparam int          EE_WORDS      = NCH * 5;
   localparam logic [4:0]  EE_LAST       = 5'(EE_WORDS - 1);
   localparam logic [4:0]  EE_STEP_DIV   = 5'h04;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] data;
   } sccu_cmd_s;

   typedef struct packed {
      logic [15:0] nominal;
      logic [15:0] mhigh;
      logic [15:0] mlow;
      logic [15:0] slew;
      logic [15:0] scale;
   } sccu_chan_s;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_STORE   = 2'b01,
      ST_RESTORE = 2'b10
   } sccu_state_e;

   typedef enum logic [1:0] {
      MG_NOM  = 2'b00,
      MG_HIGH = 2'b01,
      MG_LOW  = 2'b10
   } sccu_margin_e;
endpackage

// File: sccu_top.sv
`timescale 1ns/1ps
`default_nettype none
module sccu_top (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              clk_en,
   input  wire sccu_pkg::sccu_cmd_s cmd,
   input  wire logic [3:0]        fault_present,
   input  wire logic [3:0]        on_off_control_pin,
   input  wire logic              feedback_mode,
   input  wire logic              eeprom_clock_pin_in,
   input  wire logic              eeprom_data_pin_in,
   output logic                   eeprom_clock_pin_out,
   output logic                   eeprom_clock_pin_oe,
   output logic                   eeprom_data_pin_out,
   output logic                   eeprom_data_pin_oe,
   output logic [3:0]             supply_enable_out,
   output logic [15:0]            dac_code [4],
   output logic [15:0]            rd_data,
   output logic                   rd_valid,
   output logic                   cmd_ack,
   output logic                   busy,
   output logic                   comm_fault_flag,
   output logic [3:0]             status_flags,
   output logic                   smbalert_n
);
   import sccu_pkg::*;

   sccu_state_e       state;
   sccu_chan_s        chan [NCH];
   sccu_margin_e      margin [NCH];
   logic [7:0]        page;
   logic [7:0]        wlock;
   logic [4:0]        ee_idx;
   logic [4:0]        ee_div;
   logic              ee_ck_s1, ee_ck_s2, ee_ck_d, ee_dt_s1, ee_dt_s2;
   logic [3:0]        ctl_s1, ctl_s2;

   // Two-flop synchronisers for pins
   always_ff @(posedge clk) begin
      if (rst) begin
         ee_ck_s1 <= 1'b0;
         ee_ck_s2 <= 1'b0;
         ee_dt_s1 <= 1'b1;
         ee_dt_s2 <= 1'b1;
         ctl_s1   <= 4'h0;
         ctl_s2   <= 4'h0;
         ee_ck_d  <= 1'b0;
      end else if (clk_en) begin
         ee_ck_s1 <= eeprom_clock_pin_in;
         ee_ck_s2 <= ee_ck_s1;
         ee_dt_s1 <= eeprom_data_pin_in;
         ee_dt_s2 <= ee_dt_s1;
         ctl_s1   <= on_off_control_pin;
         ctl_s2   <= ctl_s1;
         ee_ck_d  <= ee_ck_s2;
      end
   end

   function automatic logic write_allowed(input logic [7:0] lvl, input logic [7:0] code);
      logic ok;
      ok = 1'b1;
      if (lvl == WL_ONLY_WL)
         ok = (code == CMD_WLOCK);
      else if (lvl == WL_OPS)
         ok = (code == CMD_WLOCK) || (code == CMD_OPERATION) || (code == CMD_PAGE);
      else if (lvl == WL_VOUT)
         ok = (code == CMD_WLOCK) || (code == CMD_OPERATION) || (code == CMD_PAGE) ||
              (code == CMD_ONOFF) || (code == CMD_NOMINAL);
      return ok;
   endfunction

   function automatic logic page_hits(input logic [7:0] pg, input int ch);
      return (pg == PAGE_ALL) || (pg == 8'(ch));
   endfunction

   wire idle_cmd    = cmd.valid && (state == ST_IDLE);
   wire wr_cmd      = idle_cmd && cmd.write;
   wire wr_ok       = wr_cmd && write_allowed(wlock, cmd.code);
   wire rd_cmd      = idle_cmd && !cmd.write;
   wire do_clear    = wr_ok && (cmd.code == CMD_CLEAR);
   wire do_store    = wr_ok && (cmd.code == CMD_STORE);
   wire do_restore  = wr_ok && (cmd.code == CMD_RESTORE);
   wire any_on      = |supply_enable_out;
   wire restore_bad = do_restore && any_on;
   wire ck_rise     = ee_ck_s2 && !ee_ck_d;
   wire ee_err      = (state != ST_IDLE) && ck_rise && ee_dt_s2;
   wire ee_tick     = (state != ST_IDLE) && (ee_div == EE_STEP_DIV);
   wire ee_done     = ee_tick && (ee_idx == EE_LAST);
   wire [2:0] ee_fld = 3'(ee_idx % 5);
   wire [1:0] ee_ch  = 2'(ee_idx / 5);
   wire [15:0] sel_rd = (page == PAGE_ALL) ? chan[0].nominal : chan[page[1:0]].nominal;
   logic [3:0] dac_bad;

   wire [15:0] next_rd =
      (cmd.code == CMD_PAGE)    ? {8'h00, page} :
      (cmd.code == CMD_WLOCK)   ? {8'h00, wlock} :
      (cmd.code == CMD_FEATURE) ? {8'h00, FEATURE_VALUE} :
      (cmd.code == CMD_VFORMAT) ? {8'h00, VFORMAT_VALUE} :
      (cmd.code == CMD_NOMINAL) ? sel_rd :
      (cmd.code == CMD_MHIGH)   ? chan[page[1:0]].mhigh :
      (cmd.code == CMD_MLOW)    ? chan[page[1:0]].mlow :
      (cmd.code == CMD_SLEW)    ? chan[page[1:0]].slew :
      (cmd.code == CMD_SCALE)   ? chan[page[1:0]].scale : WORD_RESET;

   wire fault_set = restore_bad || ee_err || (|dac_bad);

   always_ff @(posedge clk) begin
      if (rst) begin
         state    <= ST_IDLE;
         page     <= 8'h00;
         wlock    <= WL_RESET;
         ee_idx   <= 5'h00;
         ee_div   <= 5'h00;
         rd_data  <= WORD_RESET;
         rd_valid <= 1'b0;
         cmd_ack  <= 1'b0;
      end else if (clk_en) begin
         rd_valid <= rd_cmd;
         cmd_ack  <= wr_ok;
         if (rd_cmd)
            rd_data <= next_rd;
         if (wr_ok && cmd.code == CMD_PAGE && (cmd.data[7:0] < 8'(NCH) || cmd.data[7:0] == PAGE_ALL))
            page <= cmd.data[7:0];
         if (wr_ok && cmd.code == CMD_WLOCK)
            wlock <= cmd.data[7:0];
         unique case (state)
            ST_IDLE: begin
               ee_idx <= 5'h00;
               ee_div <= 5'h00;
               if (do_store)
                  state <= ST_STORE;
               else if (do_restore && !any_on)
                  state <= ST_RESTORE;
            end
            ST_STORE, ST_RESTORE: begin
               ee_div <= ee_tick ? 5'h00 : ee_div + 5'h01;
               if (ee_tick)
                  ee_idx <= ee_idx + 5'h01;
               if (ee_done || ee_err)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // EEPROM pins: clock driven during transfer, data released to read ack
   always_ff @(posedge clk) begin
      if (rst) begin
         eeprom_clock_pin_out <= 1'b0;
         eeprom_clock_pin_oe  <= 1'b0;
         eeprom_data_pin_out  <= 1'b0;
         eeprom_data_pin_oe   <= 1'b0;
         busy                 <= 1'b0;
      end else if (clk_en) begin
         busy                 <= (state != ST_IDLE);
         eeprom_clock_pin_oe  <= (state != ST_IDLE) && !ee_div[1];
         eeprom_clock_pin_out <= 1'b0;
         eeprom_data_pin_out  <= 1'b0;
         eeprom_data_pin_oe   <= (state == ST_STORE) && !ee_div[2] &&
                                 !chan[ee_ch].nominal[ee_fld];
      end
   end

   // Status: set beats clear, clear never touches enables
   always_ff @(posedge clk) begin
      if (rst) begin
         comm_fault_flag <= 1'b0;
         status_flags    <= 4'h0;
         smbalert_n      <= 1'b1;
      end else if (clk_en) begin
         comm_fault_flag <= fault_set | (comm_fault_flag & ~do_clear);
         status_flags    <= fault_present | (status_flags & ~{4{do_clear}});
         smbalert_n      <= !(fault_set || (|fault_present) ||
                              ((comm_fault_flag || (|status_flags)) && !do_clear));
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         wire hit      = page_hits(page, g);
         wire wr_here  = wr_ok && hit;
         wire op_cmd   = wr_here && cmd.code == CMD_OPERATION;
         wire op_on    = op_cmd && cmd.data[7];
         wire op_off   = op_cmd && !cmd.data[7];
         wire ctl_on   = ctl_s2[g] && !supply_enable_out[g];
         wire turn_on  = (op_on || ctl_on) && !supply_enable_out[g];
         wire to_high  = op_on && (cmd.data[7:0] == OP_MHIGH_IGN || cmd.data[7:0] == OP_MHIGH_ACT);
         wire to_low   = op_on && (cmd.data[7:0] == OP_MLOW_IGN || cmd.data[7:0] == OP_MLOW_ACT);
         wire to_nom   = op_on && cmd.data[7:0] == OP_NOMINAL;
         wire [15:0] tgt = to_high ? chan[g].mhigh : to_low ? chan[g].mlow : chan[g].nominal;
         wire [15:0] scaled = {chan[g].scale[15:7], 7'h00} & {9'h1FF, ~SCALE_MASK[6:0]};
         wire use_scale = !feedback_mode && (scaled != WORD_RESET);
         wire [31:0] prod = 32'(tgt) * 32'(scaled);
         wire [15:0] tgt_dac = use_scale ? prod[22:7] : tgt;
         wire margin_chg = supply_enable_out[g] && (to_high || to_low || to_nom);
         wire rate_live = !feedback_mode && chan[g].slew != RATE_HOLD;
         wire [15:0] rate = chan[g].slew;
         wire [15:0] cur = dac_code[g];
         logic [15:0] goal;
         wire [16:0] up   = 17'(cur) + 17'(rate);
         wire [15:0] step_up = (rate == RATE_FAST || up[16] || up[15:0] > goal) ? goal : up[15:0];
         wire [15:0] step_dn = (rate == RATE_FAST || rate >= cur - goal) ? goal : cur - rate;
         assign dac_bad[g] = (turn_on || margin_chg) && tgt_dac > DAC_MAX;

         always_ff @(posedge clk) begin
            if (rst) begin
               chan[g]   <= '0;
               margin[g] <= MG_NOM;
               goal      <= WORD_RESET;
               dac_code[g] <= WORD_RESET;
               supply_enable_out[g] <= 1'b0;
            end else if (clk_en) begin
               if (wr_here && cmd.code == CMD_NOMINAL)
                  chan[g].nominal <= cmd.data;
               if (wr_here && cmd.code == CMD_MHIGH)
                  chan[g].mhigh <= cmd.data;
               if (wr_here && cmd.code == CMD_MLOW)
                  chan[g].mlow <= cmd.data;
               if (wr_here && cmd.code == CMD_SLEW)
                  chan[g].slew <= cmd.data;
               if (wr_here && cmd.code == CMD_SCALE)
                  chan[g].scale <= cmd.data;
               if (state == ST_RESTORE && ee_tick && ee_ch == 2'(g))
                  chan[g].nominal[ee_fld] <= ee_dt_s2;
               // Enables move only on operation or control pin
               if (turn_on)
                  supply_enable_out[g] <= 1'b1;
               else if (op_off)
                  supply_enable_out[g] <= 1'b0;
               if (turn_on && !dac_bad[g]) begin
                  dac_code[g] <= tgt_dac;
                  goal        <= tgt_dac;
               end else if (margin_chg && !dac_bad[g] && rate_live) begin
                  goal      <= tgt_dac;
                  margin[g] <= to_high ? MG_HIGH : to_low ? MG_LOW : MG_NOM;
               end else if (rate_live && cur < goal)
                  dac_code[g] <= step_up;
               else if (rate_live && cur > goal)
                  dac_code[g] <= step_dn;
            end
         end

         a_clear_keeps_en: assert property (@(posedge clk) disable iff (rst)
            (clk_en && do_clear && !op_cmd && !ctl_on) |=> $stable(supply_enable_out[g]))
            else $error("clear changed enable");

         // Only meaningful once settled, a slew in flight moves the output anyway
         a_nominal_hold: assert property (@(posedge clk) disable iff (rst)
            (clk_en && supply_enable_out[g] && wr_here && cmd.code == CMD_NOMINAL && cur == goal)
            |=> $stable(dac_code[g]))
            else $error("nominal moved live output");
         a_mhigh_hold: assert property (@(posedge clk) disable iff (rst)
            (clk_en && supply_enable_out[g] && margin[g] == MG_HIGH && wr_here && cmd.code == CMD_MHIGH &&
             cur == goal) |=> $stable(dac_code[g]))
            else $error("margin high rewrite moved output");
         a_rate_hold: assert property (@(posedge clk) disable iff (rst)
            (clk_en && margin_chg && chan[g].slew == RATE_HOLD) |=> $stable(dac_code[g]))
            else $error("zero rate moved output");
         sequence s_fast_margin;
            clk_en && margin_chg && !dac_bad[g] && !feedback_mode && chan[g].slew == RATE_FAST;
         endsequence
         a_fast_jump: assert property (@(posedge clk) disable iff (rst)
            s_fast_margin |=> ##1 dac_code[g] == $past(tgt_dac, 2))
            else $error("fast rate did not jump");
         a_refused_keep: assert property (@(posedge clk) disable iff (rst)
            (clk_en && wr_cmd && !wr_ok && cmd.code == CMD_NOMINAL) |=> $stable(chan[g].nominal))
            else $error("refused write changed target");
      end
   endgenerate

   // Keyed on state: busy lags it by a cycle and would misjudge the last step
   sequence s_busy_cmd;
      clk_en && (state != ST_IDLE) && cmd.valid;
   endsequence
   a_busy_ignores: assert property (@(posedge clk) disable iff (rst)
      s_busy_cmd |=> !cmd_ack && !rd_valid)
      else $error("command taken while busy");
   sequence s_store_taken;
      clk_en && do_store;
   endsequence
   a_store_busy: assert property (@(posedge clk) disable iff (rst)
      s_store_taken |=> ##1 busy)
      else $error("store did not raise busy");
   a_range_flag: assert property (@(posedge clk) disable iff (rst)
      (clk_en && (|dac_bad)) |=> comm_fault_flag && !smbalert_n)
      else $error("dac range not flagged");
   a_link_error: assert property (@(posedge clk) disable iff (rst)
      (clk_en && ee_err) |=> comm_fault_flag && !smbalert_n)
      else $error("transfer error not flagged");
   a_restore_on_flt: assert property (@(posedge clk) disable iff (rst)
      (clk_en && restore_bad) |=> comm_fault_flag && !smbalert_n)
      else $error("restore while on not flagged");
   a_feature_val: assert property (@(posedge clk) disable iff (rst)
      (clk_en && rd_cmd && cmd.code == CMD_FEATURE) |=> rd_data == 16'h0090)
      else $error("bad feature byte");
   a_format_val: assert property (@(posedge clk) disable iff (rst)
      (clk_en && rd_cmd && cmd.code == CMD_VFORMAT) |=> rd_data == 16'h0040)
      else $error("bad format byte");
   a_lock_refuse: assert property (@(posedge clk) disable iff (rst)
      (clk_en && wr_cmd && wlock == WL_ONLY_WL && cmd.code != CMD_WLOCK) |=> !cmd_ack)
      else $error("locked write accepted");
   a_read_locked: assert property (@(posedge clk) disable iff (rst)
      (clk_en && rd_cmd) |=> rd_valid)
      else $error("read not answered");
   a_clear_alert: assert property (@(posedge clk) disable iff (rst)
      (clk_en && do_clear && !fault_set && fault_present == 4'h0) |=> smbalert_n && !comm_fault_flag)
      else $error("clear did not release alert");
   a_refault: assert property (@(posedge clk) disable iff (rst)
      (clk_en && fault_present != 4'h0) |=> !smbalert_n && status_flags != 4'h0)
      else $error("fault not re-reported");
endmodule
`default_nettype wire

// File: sccu_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module sccu_eeprom_model (
   input  wire logic clk,
   input  wire logic clock_line,
   input  wire logic fail_mode,
   output logic      data_oe
);
   initial data_oe = 1'b0;
   // Healthy part holds data low through each clock rise; a broken one lets the pull-up win
   always @(posedge clk) begin
      if (!clock_line) begin
         data_oe <= !fail_mode;
      end
   end
endmodule
`default_nettype wire

// File: sccu_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module sccu_top_test;
   import sccu_pkg::*;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   sccu_cmd_s         cmd = '0;
   logic [3:0]        fault_present = 4'h0;
   logic              ee_fail = 1'b0;
   logic              fb_mode = 1'b0;
   logic              scl_out, scl_oe, sda_out, sda_oe, mdl_oe;
   logic [3:0]        sup_en, status_flags;
   logic [15:0]       dac [4];
   logic [15:0]       rd_data;
   logic              rd_valid, cmd_ack, busy, comm_fault_flag, smbalert_n;
   logic              got_ack, got_rd;
   logic [15:0]       got_data;
   int                n_fail = 0;
   int                comparisons = 0;
   wire               scl_line = !scl_oe;
   wire               sda_line = !(sda_oe || mdl_oe);

   always #25 clk = !clk;

   sccu_top dut_u (
      .clk(clk), .rst(rst), .clk_en(1'b1), .cmd(cmd), .fault_present(fault_present),
      .on_off_control_pin(4'h0), .feedback_mode(fb_mode),
      .eeprom_clock_pin_in(scl_line), .eeprom_data_pin_in(sda_line),
      .eeprom_clock_pin_out(scl_out), .eeprom_clock_pin_oe(scl_oe),
      .eeprom_data_pin_out(sda_out), .eeprom_data_pin_oe(sda_oe),
      .supply_enable_out(sup_en), .dac_code(dac), .rd_data(rd_data), .rd_valid(rd_valid),
      .cmd_ack(cmd_ack), .busy(busy), .comm_fault_flag(comm_fault_flag),
      .status_flags(status_flags), .smbalert_n(smbalert_n)
   );

   sccu_eeprom_model ee_u (.clk(clk), .clock_line(scl_line), .fail_mode(ee_fail), .data_oe(mdl_oe));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One request, taken at the second edge; answers sampled just after it
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
      @(posedge clk);
      cmd <= '{1'b1, w, c, d};
      @(posedge clk);
      cmd.valid <= 1'b0;
      #1;
      got_ack = cmd_ack;
      got_rd = rd_valid;
      got_data = rd_data;
   endtask

   task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp, input string what);
      xfer(1'b0, c, 16'h0000);
      chk({15'h0000, got_rd}, 16'h0001, "read answered");
      chk(got_data, exp, what);
   endtask

   task automatic wait_dac(input int ch, input logic [15:0] v);
      for (int i = 0; i < 300 && dac[ch] !== v; i++) @(posedge clk);
      #1;
   endtask

   // Looks only after each edge has settled, so busy is never read mid-update
   task automatic wait_idle();
      for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
   endtask

   task automatic t_reports();
      rd_chk(CMD_FEATURE, 16'h0090, "feature byte");
      rd_chk(CMD_VFORMAT, 16'h0040, "format byte");
      rd_chk(CMD_WLOCK, 16'h0000, "lock level reset");
      $display("test reports done");
   endtask

   task automatic t_pages();
      for (int p = 0; p < 4; p++) begin
         xfer(1'b1, CMD_PAGE, 16'(p));
         xfer(1'b1, CMD_NOMINAL, 16'h0100 + 16'(p));
      end
      for (int p = 3; p >= 0; p--) begin
         xfer(1'b1, CMD_PAGE, 16'(p));
         rd_chk(CMD_NOMINAL, 16'h0100 + 16'(p), "own copy");
      end
      $display("test pages done");
   endtask

   task automatic t_lock();
      xfer(1'b1, CMD_WLOCK, 16'h0080);
      xfer(1'b1, CMD_NOMINAL, 16'h0AAA);
      chk({15'h0000, got_ack}, 16'h0000, "refused at 80");
      rd_chk(CMD_NOMINAL, 16'h0100, "kept value");
      xfer(1'b1, CMD_WLOCK, 16'h0040);
      xfer(1'b1, CMD_PAGE, 16'h0000);
      chk({15'h0000, got_ack}, 16'h0001, "page at 40");
      xfer(1'b1, CMD_NOMINAL, 16'h0AAA);
      chk({15'h0000, got_ack}, 16'h0000, "refused at 40");
      xfer(1'b1, CMD_WLOCK, 16'h0020);
      xfer(1'b1, CMD_MHIGH, 16'h0AAA);
      chk({15'h0000, got_ack}, 16'h0000, "refused at 20");
      xfer(1'b1, CMD_NOMINAL, 16'h0200);
      chk({15'h0000, got_ack}, 16'h0001, "nominal at 20");
      xfer(1'b1, CMD_WLOCK, 16'h0000);
      rd_chk(CMD_WLOCK, 16'h0000, "unlocked");
      $display("test lock done");
   endtask

   task automatic t_turn_on();
      xfer(1'b1, CMD_OPERATION, 16'(OP_NOMINAL));
      wait_dac(0, 16'h0200);
      chk(dac[0], 16'h0200, "target at turn-on");
      xfer(1'b1, CMD_NOMINAL, 16'h0300);
      repeat (20) @(posedge clk);
      #1;
      chk(dac[0], 16'h0200, "no change while on");
      xfer(1'b1, CMD_SLEW, RATE_HOLD);
      xfer(1'b1, CMD_MHIGH, 16'h0250);
      xfer(1'b1, CMD_OPERATION, 16'(OP_MHIGH_ACT));
      repeat (20) @(posedge clk);
      #1;
      chk(dac[0], 16'h0200, "rate zero holds");
      xfer(1'b1, CMD_SLEW, RATE_FAST);
      xfer(1'b1, CMD_OPERATION, 16'(OP_MHIGH_ACT));
      wait_dac(0, 16'h0250);
      chk(dac[0], 16'h0250, "fast margin high");
      xfer(1'b1, CMD_MHIGH, 16'h0280);
      repeat (20) @(posedge clk);
      #1;
      chk(dac[0], 16'h0250, "rewrite at margin high");
      $display("test turn on done");
   endtask

   task automatic t_clear();
      @(posedge clk);
      fault_present <= 4'h2;
      repeat (5) @(posedge clk);
      #1;
      chk({12'h000, status_flags}, 16'h0002, "fault seen");
      xfer(1'b1, CMD_CLEAR, 16'h0000);
      repeat (5) @(posedge clk);
      #1;
      chk({12'h000, status_flags}, 16'h0002, "fault set again");
      chk({15'h0000, smbalert_n}, 16'h0000, "alert again");
      chk({12'h000, sup_en}, 16'h0001, "enables kept");
      @(posedge clk);
      fault_present <= 4'h0;
      xfer(1'b1, CMD_CLEAR, 16'h0000);
      repeat (3) @(posedge clk);
      #1;
      chk({12'h000, status_flags}, 16'h0000, "all cleared");
      chk({15'h0000, smbalert_n}, 16'h0001, "alert released");
      $display("test clear done");
   endtask

   task automatic t_eeprom();
      xfer(1'b1, CMD_RESTORE, 16'h0000);
      repeat (3) @(posedge clk);
      #1;
      chk({15'h0000, comm_fault_flag}, 16'h0001, "restore while on");
      wait_idle();
      xfer(1'b1, CMD_CLEAR, 16'h0000);
      @(posedge clk);
      ee_fail <= 1'b1;
      xfer(1'b1, CMD_STORE, 16'h0000);
      @(posedge clk);
      xfer(1'b1, CMD_NOMINAL, 16'h0777);
      chk({15'h0000, got_ack}, 16'h0000, "ignored when busy");
      chk({15'h0000, busy}, 16'h0001, "busy during store");
      chk({12'h000, sup_en}, 16'h0001, "enables during store");
      chk({14'h0000, scl_out, sda_out}, 16'h0000, "open drain low");
      wait_idle();
      chk({15'h0000, comm_fault_flag}, 16'h0001, "store error");
      chk({15'h0000, smbalert_n}, 16'h0000, "store alert");
      rd_chk(CMD_NOMINAL, 16'h0300, "nominal kept");
      xfer(1'b1, CMD_CLEAR, 16'h0000);
      @(posedge clk);
      ee_fail <= 1'b0;
      xfer(1'b1, CMD_STORE, 16'h0000);
      @(posedge clk);
      #1;
      wait_idle();
      chk({15'h0000, busy}, 16'h0000, "store finished");
      chk({15'h0000, comm_fault_flag}, 16'h0000, "clean store");
      xfer(1'b1, CMD_OPERATION, 16'(OP_OFF));
      xfer(1'b1, CMD_CLEAR, 16'h0000);
      // Fault gone before restore, so only the sticky bit can hold the 4
      @(posedge clk);
      fault_present <= 4'h4;
      ee_fail <= 1'b1;
      repeat (2) @(posedge clk);
      fault_present <= 4'h0;
      xfer(1'b1, CMD_RESTORE, 16'h0000);
      @(posedge clk);
      #1;
      wait_idle();
      chk({15'h0000, comm_fault_flag}, 16'h0001, "restore error");
      chk({15'h0000, smbalert_n}, 16'h0000, "restore alert");
      chk({12'h000, status_flags}, 16'h0004, "status kept");
      @(posedge clk);
      ee_fail <= 1'b0;
      $display("test eeprom done");
   endtask

   task automatic t_limits();
      xfer(1'b1, CMD_CLEAR, 16'h0000);
      xfer(1'b1, CMD_PAGE, 16'h0001);
      xfer(1'b1, CMD_NOMINAL, 16'h0FFF);
      xfer(1'b1, CMD_OPERATION, 16'(OP_NOMINAL));
      chk({15'h0000, comm_fault_flag}, 16'h0001, "dac range fault");
      chk({15'h0000, smbalert_n}, 16'h0000, "range alert");
      chk(dac[1], 16'h0000, "dac kept in range");
      xfer(1'b1, CMD_PAGE, 16'h0000);
      xfer(1'b1, CMD_NOMINAL, 16'h0200);
      xfer(1'b1, CMD_OPERATION, 16'(OP_NOMINAL));
      xfer(1'b1, CMD_MLOW, 16'h0100);
      @(posedge clk);
      fb_mode <= 1'b1;
      xfer(1'b1, CMD_OPERATION, 16'(OP_MLOW_ACT));
      repeat (20) @(posedge clk);
      #1;
      chk(dac[0], 16'h0200, "slew ignored in feedback");
      @(posedge clk);
      fb_mode <= 1'b0;
      $display("test limits done");
   endtask

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reports();
      t_pages();
      t_lock();
      t_turn_on();
      t_clear();
      t_eeprom();
      t_limits();
      end_of_test();
   end

   // Whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
endmodule
`default_nettype wire
